// ---- mbaf_pkg.sv ----
// Package: constants and types for the mode-based access firewall
package mbaf_pkg;
  // ----------------------------------------
  // CPU modes and requesters
  // ----------------------------------------
  typedef enum logic [2:0] {
    MBAF_BOOT = 3'h0,
    MBAF_TEST = 3'h1,
    MBAF_FW   = 3'h2,
    MBAF_SYS  = 3'h3,
    MBAF_USER = 3'h4
  } mbaf_mode_t;

  typedef enum logic [1:0] {
    MBAF_SRC_CPU  = 2'h0,
    MBAF_SRC_COPY = 2'h1,
    MBAF_SRC_FDX  = 2'h2,
    MBAF_SRC_CRYP = 2'h3
  } mbaf_src_t;

  // ----------------------------------------
  // Memory regions (decoded outside)
  // ----------------------------------------
  typedef enum logic [3:0] {
    MBAF_R_ROM_BL    = 4'h0,
    MBAF_R_ROM_FW    = 4'h1,
    MBAF_R_ROM_OTHER = 4'h2,
    MBAF_R_SFL_FW    = 4'h3,
    MBAF_R_SFL_OTHER = 4'h4,
    MBAF_R_AFL_ROMZ  = 4'h5,
    MBAF_R_AFL_NVM   = 4'h6,
    MBAF_R_FW_EE     = 4'h7,
    MBAF_R_APP_EE    = 4'h8,
    MBAF_R_FW_RAM    = 4'h9,
    MBAF_R_APP_RAM   = 4'ha,
    MBAF_R_MAN_EE    = 4'hb,
    MBAF_R_NONE      = 4'hf
  } mbaf_region_t;

  // Manufacturer EEPROM sub-areas
  typedef enum logic [2:0] {
    MBAF_M_PLAIN     = 3'h0,
    MBAF_M_USER_RO   = 3'h1,
    MBAF_M_USER_WP   = 3'h2,
    MBAF_M_USER_WO   = 3'h3,
    MBAF_M_VEND_WP   = 3'h4,
    MBAF_M_BL        = 3'h5,
    MBAF_M_FUSE      = 3'h6
  } mbaf_marea_t;

  // Memory operations
  typedef enum logic [2:0] {
    MBAF_OP_READ  = 3'h0,
    MBAF_OP_WRITE = 3'h1,
    MBAF_OP_EXEC  = 3'h2,
    MBAF_OP_VZERO = 3'h3,
    MBAF_OP_VPROG = 3'h4
  } mbaf_op_t;

  // Register groups
  typedef enum logic [2:0] {
    MBAF_G_SEG   = 3'h0,
    MBAF_G_SYSM  = 3'h1,
    MBAF_G_FWALL = 3'h2,
    MBAF_G_FWOS  = 3'h3,
    MBAF_G_TEST  = 3'h4,
    MBAF_G_HW    = 3'h5,
    MBAF_G_CPU   = 3'h6
  } mbaf_grp_t;

  // Special register flags within groups
  localparam int MBAF_SF_W = 8;
  localparam int MBAF_SF_TESTONLY = 0;
  localparam int MBAF_SF_BANKED = 1;
  localparam int MBAF_SF_CSR = 2;
  localparam int MBAF_SF_CLKSEL = 3;
  localparam int MBAF_SF_ESIZE = 4;
  localparam int MBAF_SF_HIDDEN = 5;
  localparam int MBAF_SF_RNG = 6;
  localparam int MBAF_SF_KEY = 7;

  // ----------------------------------------
  // Firewall register map
  // ----------------------------------------
  localparam int MBAF_AW = 4;
  localparam logic [3:0] MBAF_A_NVMCHK = 4'h0;
  localparam logic [3:0] MBAF_A_WBASL = 4'h1;
  localparam logic [3:0] MBAF_A_WBASH = 4'h2;
  localparam logic [3:0] MBAF_A_WSZL = 4'h3;
  localparam logic [3:0] MBAF_A_WSZH = 4'h4;
  localparam logic [3:0] MBAF_A_HWRL = 4'h5;
  localparam logic [3:0] MBAF_A_HWRH = 4'h6;
  localparam logic [3:0] MBAF_A_SEGPTRL = 4'h7;
  localparam logic [3:0] MBAF_A_SEGPTRH = 4'h8;
  localparam logic [3:0] MBAF_A_STATUS = 4'h9;
  localparam logic [7:0] MBAF_RST_VAL = 8'h00;

  // Bits in the NVM check permission register
  localparam int MBAF_NC_AFL_VZERO = 0;
  localparam int MBAF_NC_AFL_VPROG = 1;
  localparam int MBAF_NC_AEE_VZERO = 2;
endpackage

// ---- mbaf_mem_check.sv ----
// Memory access decision by mode, region and operation
module mbaf_mem_check
  import mbaf_pkg::*;
(
  input wire mbaf_mode_t mode,
  input wire mbaf_src_t src,
  input wire mbaf_region_t region,
  input wire mbaf_marea_t marea,
  input wire mbaf_op_t op,
  input wire logic prot_bit,
  input wire logic wo_written,
  input wire logic wo_top3,
  input wire logic vend_nibble,
  input wire logic seg_r,
  input wire logic seg_w,
  input wire logic seg_x,
  input wire logic [7:0] nvm_chk,
  input wire logic in_fw_window,
  input wire logic in_crypto_ram,
  input wire logic fetch_nvm,
  input wire logic opt_rom_rd_nvm,
  input wire logic opt_ram_exec,
  input wire logic opt_copy_rom,
  input wire logic opt_copy_nvm,
  output logic allow
);
  logic rd, wr, ex, vz, vp;
  logic base_ok, man_ok, romlike, nvmlike;

  assign rd = (op == MBAF_OP_READ);
  assign wr = (op == MBAF_OP_WRITE);
  assign ex = (op == MBAF_OP_EXEC);
  assign vz = (op == MBAF_OP_VZERO);
  assign vp = (op == MBAF_OP_VPROG);
  assign romlike = (region == MBAF_R_ROM_BL) || (region == MBAF_R_ROM_FW) ||
                   (region == MBAF_R_ROM_OTHER) || (region == MBAF_R_AFL_ROMZ);
  assign nvmlike = (region == MBAF_R_AFL_NVM) || (region == MBAF_R_APP_EE) ||
                   (region == MBAF_R_FW_EE) || (region == MBAF_R_MAN_EE);

  // Manufacturer area write policy
  always_comb begin
    man_ok = 1'b0;
    case (mode)
      MBAF_BOOT, MBAF_TEST: man_ok = 1'b1; // R2 R3
      MBAF_FW: begin
        case (marea) // R5
          MBAF_M_USER_WO: man_ok = !wo_written;
          MBAF_M_VEND_WP: man_ok = !prot_bit; // R6
          MBAF_M_BL: man_ok = 1'b1;
          default: man_ok = 1'b0;
        endcase
      end
      MBAF_SYS: begin
        case (marea) // R8 R9
          MBAF_M_PLAIN: man_ok = 1'b1;
          MBAF_M_USER_WP: man_ok = !prot_bit; // R6
          MBAF_M_USER_WO: man_ok = !wo_written && !wo_top3;
          MBAF_M_VEND_WP: man_ok = vend_nibble && !prot_bit;
          default: man_ok = 1'b0;
        endcase
      end
      MBAF_USER: man_ok = (marea == MBAF_M_PLAIN) && seg_w; // R11
      default: man_ok = 1'b0;
    endcase
  end

  // Base policy for CPU accesses
  always_comb begin
    base_ok = 1'b0;
    case (mode)
      MBAF_BOOT: begin
        case (region)
          MBAF_R_ROM_FW, MBAF_R_ROM_OTHER, MBAF_R_SFL_FW: base_ok = rd || ex; // R1
          MBAF_R_FW_EE: base_ok = rd || wr; // R2
          MBAF_R_MAN_EE: base_ok = rd || wr || ex; // R2
          MBAF_R_FW_RAM: base_ok = rd || wr || ex; // R2
          default: base_ok = 1'b0;
        endcase
      end
      MBAF_TEST: begin
        case (region)
          MBAF_R_ROM_BL: base_ok = rd; // R3
          MBAF_R_ROM_FW, MBAF_R_ROM_OTHER: base_ok = rd || ex; // R3
          MBAF_R_NONE: base_ok = 1'b0;
          default: base_ok = rd || wr || ex; // R3
        endcase
      end
      MBAF_FW: begin
        case (region)
          MBAF_R_ROM_FW: base_ok = rd || ex; // R4
          MBAF_R_SFL_FW, MBAF_R_FW_RAM: base_ok = rd || wr || ex; // R4
          MBAF_R_FW_EE: base_ok = rd || wr; // R4
          MBAF_R_MAN_EE: base_ok = rd || ex || (wr && man_ok); // R5
          MBAF_R_AFL_ROMZ, MBAF_R_AFL_NVM:
            base_ok = (vz && nvm_chk[MBAF_NC_AFL_VZERO]) || (vp && nvm_chk[MBAF_NC_AFL_VPROG]); // R12
          MBAF_R_APP_EE: base_ok = vz && nvm_chk[MBAF_NC_AEE_VZERO]; // R12
          MBAF_R_APP_RAM: base_ok = in_fw_window && (rd || wr); // R13
          default: base_ok = 1'b0;
        endcase
      end
      MBAF_SYS: begin
        case (region)
          MBAF_R_AFL_ROMZ: base_ok = rd || ex; // R7
          MBAF_R_AFL_NVM, MBAF_R_APP_EE, MBAF_R_APP_RAM: base_ok = rd || wr || ex; // R7
          MBAF_R_MAN_EE: base_ok = rd || ex || (wr && man_ok); // R8 R9
          default: base_ok = 1'b0;
        endcase
      end
      MBAF_USER: begin
        case (region)
          MBAF_R_AFL_ROMZ, MBAF_R_AFL_NVM, MBAF_R_APP_EE: base_ok = (rd && seg_r) || (ex && seg_x); // R10
          MBAF_R_APP_RAM: base_ok = (rd && seg_r) || (wr && seg_w) || (ex && seg_x); // R10
          MBAF_R_MAN_EE: base_ok = (marea != MBAF_M_VEND_WP) && (marea != MBAF_M_FUSE) &&
                                   ((rd && seg_r) || (ex && seg_x) || (wr && man_ok)); // R11
          default: base_ok = 1'b0;
        endcase
      end
      default: base_ok = 1'b0;
    endcase
  end

  // Build-time denials and requester overrides
  always_comb begin
    allow = base_ok;
    if (!opt_rom_rd_nvm && fetch_nvm && rd && romlike) allow = 1'b0; // R15
    if (!opt_ram_exec && ex && ((region == MBAF_R_FW_RAM) || (region == MBAF_R_APP_RAM))) allow = 1'b0; // R15
    case (src)
      MBAF_SRC_COPY: begin
        if (!opt_copy_rom && romlike) allow = 1'b0; // R15
        if (!opt_copy_nvm && nvmlike) allow = 1'b0; // R15
      end
      MBAF_SRC_FDX: begin
        if ((mode != MBAF_USER) && (romlike || nvmlike || (region == MBAF_R_SFL_FW) ||
            (region == MBAF_R_SFL_OTHER))) allow = 1'b0; // R16
      end
      MBAF_SRC_CRYP: allow = in_crypto_ram && (rd || wr); // R14
      default: ;
    endcase
    if (region == MBAF_R_NONE) allow = 1'b0;
  end
endmodule

// ---- mbaf_sfr_check.sv ----
// Special function register access decision
module mbaf_sfr_check
  import mbaf_pkg::*;
(
  input wire mbaf_mode_t mode,
  input wire mbaf_grp_t grp,
  input wire logic [MBAF_SF_W-1:0] sflag,
  input wire logic wr,
  input wire logic hw_right,
  output logic allow
);
  logic g_ok;

  always_comb begin
    g_ok = 1'b0;
    case (mode)
      MBAF_BOOT: g_ok = (grp != MBAF_G_SEG) && !sflag[MBAF_SF_BANKED] && !sflag[MBAF_SF_TESTONLY]; // R17
      MBAF_TEST: g_ok = (grp != MBAF_G_SEG) && !sflag[MBAF_SF_BANKED]; // R17
      MBAF_FW: begin
        case (grp)
          MBAF_G_FWALL: g_ok = !wr; // R18 R23
          MBAF_G_FWOS: g_ok = 1'b1; // R18
          MBAF_G_CPU: g_ok = !sflag[MBAF_SF_BANKED]; // R18 R23
          MBAF_G_HW: g_ok = hw_right || (!wr && sflag[MBAF_SF_CLKSEL]); // R18 R22
          MBAF_G_SYSM: g_ok = !wr && sflag[MBAF_SF_CSR]; // R22
          MBAF_G_TEST: g_ok = !wr && sflag[MBAF_SF_ESIZE]; // R22
          default: g_ok = 1'b0;
        endcase
      end
      MBAF_SYS: g_ok = (grp == MBAF_G_SEG) || (grp == MBAF_G_SYSM) || (grp == MBAF_G_FWALL) ||
                       (grp == MBAF_G_HW) || (grp == MBAF_G_CPU); // R19
      MBAF_USER: begin
        case (grp)
          MBAF_G_CPU: g_ok = 1'b1; // R20
          MBAF_G_HW: g_ok = hw_right; // R20
          MBAF_G_SYSM: g_ok = !wr && sflag[MBAF_SF_CSR]; // R22
          default: g_ok = 1'b0;
        endcase
      end
      default: g_ok = 1'b0;
    endcase
    allow = g_ok;
    if (!wr && (sflag[MBAF_SF_HIDDEN] || sflag[MBAF_SF_KEY])) allow = 1'b0; // R24
    if (wr && sflag[MBAF_SF_RNG]) allow = 1'b0; // R24
  end
endmodule

// ---- mbaf_firewall.sv ----
// Top of the mode-based access firewall: registers, checkers, verdict flops
// Function
// R1 - Boot: read/exec ROM except bootloader; read/exec firmware OS support flash.
// R2 - Boot: read/write firmware EEPROM; full access manufacturer EEPROM and firmware RAM.
// R3 - Test: ROM read/exec, no exec in bootloader; full Flash, EEPROM, RAM.
// R4 - Firmware: own ROM read/exec, own flash and RAM full, EEPROM read/write.
// R5 - Firmware: manufacturer area read/exec; write-once, protectable, bootloader writes.
// R6 - Protectable write refused when the byte's protect bit is set.
// R7 - System: ROMinized flash read/exec; other application memories full access.
// R8 - System: user read-only unwritable, protectable user area, write-once minus top-3 byte.
// R9 - System: vendor area unwritable except protectable upper nibble of one byte.
// R10 - User: application memories only as segment rights allow.
// R11 - User: never read/exec vendor area; fuse area limits hold.
// R12 - Firmware: NVM verify checks only when check-permission bits set.
// R13 - Firmware: read/write inside the configured application-RAM window.
// R14 - Crypto coprocessor reads and writes its operand RAM.
// R15 - Disabled build options block NVM-to-ROM reads, RAM exec, copy reads.
// R16 - Full-duplex copy: no ROM/Flash/EEPROM outside user mode; never registers.
// R17 - Boot/test: all groups but segmentation and banked; boot not test-only.
// R18 - Firmware: read firewall, firmware and general CPU; hardware by rights.
// R19 - System: segmentation, system, firewall, hardware and CPU groups.
// R20 - User: CPU registers; hardware per fetch segment rights.
// R21 - Copy transfer keeps register rights it was launched with.
// R22 - Extra reads: control/status, clock-select, memory-size test.
// R23 - Deny segmentation outside system, banked outside sys/user, firmware firewall writes.
// R24 - Hidden pointer and key registers unreadable; random number read-only.
// R25 - Denied register access raises an exception.
// R26 - Segmentation registers reset to zero, disabling user segments.
//
// The strobed register port and the register addresses are this design's own decisions.
module mbaf_firewall
  import mbaf_pkg::*;
#(
  parameter int HW_RIGHTS_W = 16,
  parameter int RAM_AW = 16,
  parameter int CRYPTO_BASE = 'h0000,
  parameter int CRYPTO_SIZE = 'h0400
)
(
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire logic [MBAF_AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Current mode and segment info
  input wire mbaf_mode_t cpu_mode,
  input wire logic seg_r,
  input wire logic seg_w,
  input wire logic seg_x,
  input wire logic [HW_RIGHTS_W-1:0] seg_hw_rights,
  // Memory access request
  input wire logic mem_req,
  input wire mbaf_src_t mem_src,
  input wire mbaf_region_t mem_region,
  input wire mbaf_marea_t mem_marea,
  input wire mbaf_op_t mem_op,
  input wire logic [RAM_AW-1:0] mem_ram_addr,
  input wire logic mem_prot_bit,
  input wire logic mem_wo_written,
  input wire logic mem_wo_top3,
  input wire logic mem_vend_nibble,
  input wire logic mem_fetch_nvm,
  // Build options
  input wire logic opt_rom_rd_nvm,
  input wire logic opt_ram_exec,
  input wire logic opt_copy_rom,
  input wire logic opt_copy_nvm,
  // Register access request
  input wire logic sfr_req,
  input wire mbaf_src_t sfr_src,
  input wire mbaf_grp_t sfr_grp,
  input wire logic [MBAF_SF_W-1:0] sfr_flags,
  input wire logic [$clog2(HW_RIGHTS_W)-1:0] sfr_hw_idx,
  input wire logic sfr_wr,
  // Copy engine launch
  input wire logic copy_start,
  input wire logic copy_done,
  // Verdicts
  output logic mem_grant,
  output logic mem_deny,
  output logic sfr_grant,
  output logic sfr_exception
);
  // ----------------------------------------
  // Firewall registers
  // ----------------------------------------
  logic [7:0] nvm_chk_q, wbasl_q, wbash_q, wszl_q, wszh_q, hwrl_q, hwrh_q, segl_q, segh_q;
  logic [7:0] rdata_q;
  logic sys_w, copy_busy_q;

  // Only system mode writes firewall and segmentation regs
  assign sys_w = reg_wr && (cpu_mode == MBAF_SYS); // R23

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nvm_chk_q <= MBAF_RST_VAL;
      wbasl_q <= MBAF_RST_VAL;
      wbash_q <= MBAF_RST_VAL;
      wszl_q <= MBAF_RST_VAL;
      wszh_q <= MBAF_RST_VAL;
      hwrl_q <= MBAF_RST_VAL;
      hwrh_q <= MBAF_RST_VAL;
      segl_q <= MBAF_RST_VAL; // R26
      segh_q <= MBAF_RST_VAL; // R26
    end else begin
      if (sys_w && reg_addr == MBAF_A_NVMCHK) nvm_chk_q <= reg_wdata;
      if (sys_w && reg_addr == MBAF_A_WBASL) wbasl_q <= reg_wdata;
      if (sys_w && reg_addr == MBAF_A_WBASH) wbash_q <= reg_wdata;
      if (sys_w && reg_addr == MBAF_A_WSZL) wszl_q <= reg_wdata;
      if (sys_w && reg_addr == MBAF_A_WSZH) wszh_q <= reg_wdata;
      if (sys_w && reg_addr == MBAF_A_HWRL) hwrl_q <= reg_wdata;
      if (sys_w && reg_addr == MBAF_A_HWRH) hwrh_q <= reg_wdata;
      if (sys_w && reg_addr == MBAF_A_SEGPTRL) segl_q <= reg_wdata;
      if (sys_w && reg_addr == MBAF_A_SEGPTRH) segh_q <= reg_wdata;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [7:0] rd_mux;
  logic seg_zero;
  logic [7:0] status;

  // Segment table disabled while pointer is zero
  assign seg_zero = (segl_q == 8'h00) && (segh_q == 8'h00); // R26
  assign status = {4'h0, seg_zero, copy_busy_q, sfr_exception, mem_deny};

  always_comb begin
    case (reg_addr)
      MBAF_A_NVMCHK: rd_mux = nvm_chk_q;
      MBAF_A_WBASL: rd_mux = wbasl_q;
      MBAF_A_WBASH: rd_mux = wbash_q;
      MBAF_A_WSZL: rd_mux = wszl_q;
      MBAF_A_WSZH: rd_mux = wszh_q;
      MBAF_A_HWRL: rd_mux = hwrl_q;
      MBAF_A_HWRH: rd_mux = hwrh_q;
      MBAF_A_SEGPTRL: rd_mux = (cpu_mode == MBAF_SYS) ? segl_q : 8'h00; // R23
      MBAF_A_SEGPTRH: rd_mux = (cpu_mode == MBAF_SYS) ? segh_q : 8'h00; // R23
      MBAF_A_STATUS: rd_mux = status;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rdata_q <= 8'h00;
    else rdata_q <= reg_rd ? rd_mux : 8'h00;
  end
  assign reg_rdata = rdata_q;

  // ----------------------------------------
  // Copy engine right capture
  // ----------------------------------------
  mbaf_mode_t copy_mode_q;
  logic [HW_RIGHTS_W-1:0] copy_rights_q;
  logic [HW_RIGHTS_W-1:0] fw_rights, live_rights;

  assign fw_rights = HW_RIGHTS_W'({hwrh_q, hwrl_q});
  assign live_rights = (cpu_mode == MBAF_USER) ? seg_hw_rights : fw_rights;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      copy_busy_q <= 1'b0;
      copy_mode_q <= MBAF_BOOT;
      copy_rights_q <= '0;
    end else if (copy_start) begin
      copy_busy_q <= 1'b1; // R21
      copy_mode_q <= cpu_mode; // R21
      copy_rights_q <= live_rights; // R21
    end else if (copy_done) begin
      copy_busy_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checkers
  // ----------------------------------------
  logic in_win, in_cry, mem_ok, sfr_ok, sfr_ok_chk;
  logic [RAM_AW-1:0] wbase, wsize;
  logic [RAM_AW:0] wend;
  mbaf_mode_t sfr_mode;
  logic [HW_RIGHTS_W-1:0] sfr_rights;

  assign wbase = RAM_AW'({wbash_q, wbasl_q});
  assign wsize = RAM_AW'({wszh_q, wszl_q});
  assign wend = {1'b0, wbase} + {1'b0, wsize};
  assign in_win = ({1'b0, mem_ram_addr} >= {1'b0, wbase}) && ({1'b0, mem_ram_addr} < wend); // R13
  assign in_cry = (mem_ram_addr >= RAM_AW'(CRYPTO_BASE)) &&
                  ({1'b0, mem_ram_addr} < (RAM_AW+1)'(CRYPTO_BASE + CRYPTO_SIZE)); // R14

  mbaf_mem_check u_mem (
    .mode(cpu_mode),
    .src(mem_src),
    .region(mem_region),
    .marea(mem_marea),
    .op(mem_op),
    .prot_bit(mem_prot_bit),
    .wo_written(mem_wo_written),
    .wo_top3(mem_wo_top3),
    .vend_nibble(mem_vend_nibble),
    .seg_r(seg_r && !seg_zero), // R26
    .seg_w(seg_w && !seg_zero), // R26
    .seg_x(seg_x && !seg_zero), // R26
    .nvm_chk(nvm_chk_q),
    .in_fw_window(in_win),
    .in_crypto_ram(in_cry),
    .fetch_nvm(mem_fetch_nvm),
    .opt_rom_rd_nvm(opt_rom_rd_nvm),
    .opt_ram_exec(opt_ram_exec),
    .opt_copy_rom(opt_copy_rom),
    .opt_copy_nvm(opt_copy_nvm),
    .allow(mem_ok)
  );

  // Copy engine register accesses use the frozen rights while a copy is busy
  assign sfr_mode = (sfr_src == MBAF_SRC_COPY && copy_busy_q) ? copy_mode_q : cpu_mode; // R21
  assign sfr_rights = (sfr_src == MBAF_SRC_COPY && copy_busy_q) ? copy_rights_q : live_rights; // R21

  mbaf_sfr_check u_sfr (
    .mode(sfr_mode),
    .grp(sfr_grp),
    .sflag(sfr_flags),
    .wr(sfr_wr),
    .hw_right(sfr_rights[sfr_hw_idx]),
    .allow(sfr_ok_chk)
  );

  assign sfr_ok = sfr_ok_chk && (sfr_src != MBAF_SRC_FDX) && (sfr_src != MBAF_SRC_CRYP); // R16

  // ----------------------------------------
  // Registered verdicts
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_grant <= 1'b0;
      mem_deny <= 1'b0;
      sfr_grant <= 1'b0;
      sfr_exception <= 1'b0;
    end else begin
      mem_grant <= mem_req && mem_ok;
      mem_deny <= mem_req && !mem_ok;
      sfr_grant <= sfr_req && sfr_ok;
      sfr_exception <= sfr_req && !sfr_ok; // R25
    end
  end
endmodule

// ---- mbaf_firewall_assertions.sv ----
// Checker: port-level properties of the access firewall
module mbaf_firewall_assertions
  import mbaf_pkg::*;
(
  input logic clk,
  input logic arst_n,
  input logic reg_rd,
  input logic [7:0] reg_rdata,
  input mbaf_mode_t cpu_mode,
  input logic seg_r,
  input logic mem_req,
  input mbaf_src_t mem_src,
  input mbaf_region_t mem_region,
  input mbaf_marea_t mem_marea,
  input mbaf_op_t mem_op,
  input logic mem_prot_bit,
  input logic sfr_req,
  input mbaf_src_t sfr_src,
  input mbaf_grp_t sfr_grp,
  input logic [MBAF_SF_W-1:0] sfr_flags,
  input logic sfr_wr,
  input logic mem_grant,
  input logic mem_deny,
  input logic sfr_grant,
  input logic sfr_exception
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic cpu_mem = mem_req && mem_src == MBAF_SRC_CPU;
  wire logic cpu_sfr = sfr_req && sfr_src == MBAF_SRC_CPU;
  // Outside user mode, RAM is the only place the full-duplex engine may reach
  wire logic nvm = mem_region != MBAF_R_FW_RAM && mem_region != MBAF_R_APP_RAM && mem_region != MBAF_R_NONE;

  a_mem_one_verdict: assert property (mem_req |=> mem_grant != mem_deny) else $error("mem verdict");
  a_sfr_one_verdict: assert property (sfr_req |=> sfr_grant != sfr_exception) else $error("sfr verdict");
  a_sfr_idle_quiet: assert property (!sfr_req |=> !sfr_exception && !sfr_grant) else $error("sfr idle");
  a_boot_bl_deny: assert property (cpu_mem && cpu_mode == MBAF_BOOT && mem_region == MBAF_R_ROM_BL |=> mem_deny)
    else $error("boot loader");
  a_user_seg_deny: assert property (cpu_mem && cpu_mode == MBAF_USER && mem_region == MBAF_R_APP_RAM
    && mem_op == MBAF_OP_READ && !seg_r |=> mem_deny) else $error("segment read");
  a_prot_write_deny: assert property (cpu_mem && cpu_mode == MBAF_FW && mem_region == MBAF_R_MAN_EE
    && mem_marea == MBAF_M_VEND_WP && mem_op == MBAF_OP_WRITE && mem_prot_bit |=> mem_deny) else $error("prot");
  a_fdx_nvm_deny: assert property (mem_req && mem_src == MBAF_SRC_FDX && cpu_mode != MBAF_USER && nvm
    |=> mem_deny) else $error("duplex nvm");
  a_fdx_sfr_deny: assert property (sfr_req && sfr_src == MBAF_SRC_FDX |=> sfr_exception) else $error("duplex");
  a_seg_sys_only: assert property (cpu_sfr && sfr_grp == MBAF_G_SEG && cpu_mode != MBAF_SYS |=> sfr_exception)
    else $error("seg group");
  a_key_unreadable: assert property (sfr_req && !sfr_wr && sfr_flags[MBAF_SF_KEY] |=> sfr_exception)
    else $error("key read");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("rdata idle");

  c_mem_grant: cover property (mem_req ##1 mem_grant);
  c_mem_deny: cover property (mem_req ##1 mem_deny);
  c_sfr_exc: cover property (sfr_req ##1 sfr_exception);
endmodule

bind mbaf_firewall mbaf_firewall_assertions u_chk (.*);

// ---- mbaf_cpu_model.sv ----
// CPU-side partner: privilege mode, segment rights and copy launch
module mbaf_cpu_model
  import mbaf_pkg::*;
(
  input wire logic clk,
  output mbaf_mode_t cpu_mode = MBAF_BOOT,
  output logic [2:0] seg_rwx = 3'b000,
  output logic [15:0] seg_hw_rights = 16'h0000,
  output logic copy_start = 1'b0,
  output logic copy_done = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Mode switches land on an edge, as the core's own would
  task automatic set(input mbaf_mode_t m, input logic [2:0] rwx, input logic [15:0] hw = 16'h0001);
    @(posedge clk);
    cpu_mode <= m;
    seg_rwx <= rwx;
    seg_hw_rights <= hw;
  endtask
  task automatic pulse(input logic done);
    @(posedge clk);
    copy_start <= !done;
    copy_done <= done;
    @(posedge clk);
    copy_start <= 1'b0;
    copy_done <= 1'b0;
  endtask
endmodule

// ---- mbaf_firewall_bench.sv ----
// Testbench for the mode-based access firewall
module mbaf_firewall_bench
  import mbaf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, arst_n = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, mem_req = 1'b0, sfr_req = 1'b0, sfr_wr = 1'b0;
  logic [3:0] reg_addr = 4'h0, sfr_hw_idx = 4'h0;
  logic [7:0] reg_wdata = 8'h00, sfr_flags = 8'h00, reg_rdata;
  logic mem_prot_bit = 1'b0, mem_wo_written = 1'b0, mem_wo_top3 = 1'b0, mem_vend_nibble = 1'b0;
  logic mem_fetch_nvm = 1'b0, opt_rom_rd_nvm = 1'b1, opt_ram_exec = 1'b1, opt_copy_rom = 1'b1, opt_copy_nvm = 1'b1;
  logic [15:0] mem_ram_addr = 16'h0000, seg_hw_rights;
  logic [2:0] seg_rwx, rwx = 3'b111;
  logic mem_grant, mem_deny, sfr_grant, sfr_exception, copy_start, copy_done;
  mbaf_mode_t cpu_mode;
  mbaf_src_t mem_src = MBAF_SRC_CPU, sfr_src = MBAF_SRC_CPU;
  mbaf_region_t mem_region = MBAF_R_NONE;
  mbaf_marea_t mem_marea = MBAF_M_PLAIN;
  mbaf_op_t mem_op = MBAF_OP_READ;
  mbaf_grp_t sfr_grp = MBAF_G_CPU;
  int mismatches = 0, total_checks = 0;
  // Fields: mem {mode,region,op,area,flags,grant}; sfr {mode,grp,flags,wr,idx,grant}
  localparam logic [23:0] MT [39] = '{24'h000000, 24'h022001, 24'h032001,
    24'h071001, 24'h072000, 24'h0b1001, 24'h092001, 24'h100001, 24'h102000, 24'h121000, 24'h151001,
    24'h212001, 24'h220000, 24'h231001, 24'h271001, 24'h292001, 24'h2a0000,
    24'h2b0001, 24'h2b1480, 24'h2b1401, 24'h2b1340, 24'h2b1301, 24'h2b1501,
    24'h351000, 24'h352001, 24'h361001, 24'h382001, 24'h3a2001,
    24'h3b1100, 24'h3b1280, 24'h3b1201, 24'h3b1340, 24'h3b1320, 24'h3b1301,
    24'h3b1400, 24'h3b1411, 24'h3b1490, 24'h4b0400, 24'h4b2400};
  localparam logic [27:0] ST [31] = '{28'h0401000, 28'h1401001, 28'h0000000, 28'h1602000, 28'h0500101,
    28'h3000101, 28'h3100001, 28'h3200101, 28'h3500101, 28'h3602001,
    28'h2200001, 28'h2200100, 28'h2300101, 28'h2600101, 28'h2602000, 28'h2500121, 28'h2500130, 28'h2000000,
    28'h2508031, 28'h2410001, 28'h2104001, 28'h4104001,
    28'h4600101, 28'h4500101, 28'h4500110, 28'h4000000, 28'h4602001,
    28'h3120000, 28'h3540100, 28'h3540001, 28'h3580000};

  mbaf_cpu_model u_cpu (.*);
  mbaf_firewall u_dut (.*, .seg_r(seg_rwx[2]), .seg_w(seg_rwx[1]), .seg_x(seg_rwx[0]));

  always #12.5 clk = ~clk;

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic mem(input logic [23:0] v, input mbaf_src_t s = MBAF_SRC_CPU, input logic [15:0] ad = 16'h0000);
    u_cpu.set(mbaf_mode_t'(v[22:20]), rwx);
    mem_req <= 1'b1;
    mem_src <= s;
    mem_region <= mbaf_region_t'(v[19:16]);
    mem_op <= mbaf_op_t'(v[14:12]);
    mem_marea <= mbaf_marea_t'(v[10:8]);
    {mem_prot_bit, mem_wo_written, mem_wo_top3, mem_vend_nibble} <= v[7:4];
    mem_ram_addr <= ad;
    @(posedge clk);
    mem_req <= 1'b0;
    #1;
    chk(mem_grant, v[0]);
    chk(mem_deny, !v[0]);
  endtask
  task automatic sfr(input logic [27:0] v, input mbaf_src_t s = MBAF_SRC_CPU);
    u_cpu.set(mbaf_mode_t'(v[26:24]), rwx);
    sfr_req <= 1'b1;
    sfr_src <= s;
    sfr_grp <= mbaf_grp_t'(v[22:20]);
    {sfr_flags, sfr_wr, sfr_hw_idx} <= {v[19:12], v[8], v[7:4]};
    @(posedge clk);
    sfr_req <= 1'b0;
    #1;
    chk(sfr_grant, v[0]);
    chk(sfr_exception, !v[0]);
  endtask
  task automatic rw(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    {reg_wr, reg_rd} <= {w, !w};
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    {reg_wr, reg_rd} <= 2'b00;
    #1;
    if (!w) chk(reg_rdata, d);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic t_seg;
    mem(24'h4a0000);
    u_cpu.set(MBAF_SYS, rwx);
    rw(1'b0, MBAF_A_SEGPTRL, 8'h00);
    rw(1'b0, 4'hf, 8'h00);
    rw(1'b1, MBAF_A_SEGPTRL, 8'h01);
    rw(1'b0, MBAF_A_SEGPTRL, 8'h01);
    rwx = 3'b100;
    mem(24'h4a0001);
    mem(24'h4a1000);
    rwx = 3'b111;
    $display("test seg done");
  endtask
  task automatic t_fw;
    u_cpu.set(MBAF_SYS, rwx);
    rw(1'b1, MBAF_A_NVMCHK, 8'h01);
    rw(1'b1, MBAF_A_WBASH, 8'h10);
    rw(1'b1, MBAF_A_WSZH, 8'h01);
    rw(1'b1, MBAF_A_HWRL, 8'h04);
    u_cpu.set(MBAF_FW, rwx);
    rw(1'b1, MBAF_A_NVMCHK, 8'h00);
    rw(1'b0, MBAF_A_NVMCHK, 8'h01);
    mem(24'h263001);
    mem(24'h264000);
    mem(24'h283000);
    mem(24'h2a1001, MBAF_SRC_CPU, 16'h10ff);
    mem(24'h2a1000, MBAF_SRC_CPU, 16'h1100);
    mem(24'h3a1001, MBAF_SRC_CRYP, 16'h03ff);
    mem(24'h3a1000, MBAF_SRC_CRYP, 16'h0400);
    $display("test fw done");
  endtask
  task automatic t_sfr;
    foreach (ST[i]) sfr(ST[i]);
    sfr(28'h3600000, MBAF_SRC_FDX);
    u_cpu.set(MBAF_SYS, rwx);
    u_cpu.pulse(1'b0);
    sfr(28'h4000001, MBAF_SRC_COPY);
    u_cpu.pulse(1'b1);
    sfr(28'h4000000, MBAF_SRC_COPY);
    $display("test sfr done");
  endtask
  task automatic t_opt;
    mem(24'h160000, MBAF_SRC_FDX);
    @(posedge clk);
    {opt_ram_exec, opt_copy_rom, opt_copy_nvm, opt_rom_rd_nvm, mem_fetch_nvm} <= 5'b00001;
    mem(24'h3a2000);
    mem(24'h350000);
    mem(24'h350000, MBAF_SRC_COPY);
    mem(24'h380000, MBAF_SRC_COPY);
    $display("test opt done");
  endtask

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_seg();
    foreach (MT[i]) mem(MT[i]);
    $display("test mem done");
    t_fw();
    t_sfr();
    t_opt();
    report_and_stop();
  end
  // Whole run is a few hundred cycles; this cuts a hang
  initial begin
    #50us;
    mismatches++;
    report_and_stop();
  end
endmodule
